// ### logic/data_converter_control_cfg.svh
// Register map, field positions, reset values and timing of the data converter
// Behaviour
// - One 10-bit SAR engine, used as ADC or DAC, one mode at a time.
// - Eight-way mux: seven single-ended inputs or three differential pairs.
// - Sampled level is held for the whole conversion.
// - DAC mode runs the engine in reverse onto the second port pins.
// - Result read through a low and a high byte forming one word.
// - Reference is internal 1.0V or half supply; sets the result scale.
// - Results are signed two's complement; single-ended is relative to half supply.
// - Result sits right- or left-aligned in the 16-bit pair.
// - Right: sign copied to top 6 bits. Left: low 6 bits zero.
// - Left-align bit set selects left alignment for 8-bit reads of the high byte.
// - Data pair readable only in ADC mode, writable only in DAC mode.
// - Codes map between alignments by a plain 6-bit shift.
// - A conversion takes 6.5 us at the intended converter clock.
// - Conversions start singly by software or repeatedly by a timer.
// - Each completed conversion raises an interrupt request.
// - Input selection also offers temperature sensor and supply channels.
// - Thirteen converter cycles; input sampled in the third, then held.
// - At the end the done flag is set and the result stored, little delay.
// - Start only while enabled; busy holds during conversion, cleared at the end.
// - Enable bit turns the converter on; clear means no power drawn.
`ifndef DATA_CONVERTER_CONTROL_CFG_SVH
`define DATA_CONVERTER_CONTROL_CFG_SVH
`define CTL_ADDR 4'h0
`define SEL_ADDR 4'h1
`define RLO_ADDR 4'h2
`define RHI_ADDR 4'h3
`define CTL_EN 7
`define CTL_GO 6
`define CTL_LEFT_ALIGN_SELECT 5
`define CTL_DONE 4
`define CTL_DAC 3
`define CTL_REFI 2
`define CTL_REFUSED 1
`define CTL_OVERRUN 0
`define SEL_RST 8'h00
`define WORD_RST 16'h0000
`define CODE_MID 10'h200
`define INT_CHAN 3'h3
`define CLK_PERIOD_NS 100
`define CONV_TIME_NS 6500
`define CONV_CYCLES 13
`define SAMPLE_CYC 4'h3
`define TICK_SYS ((`CONV_TIME_NS / `CONV_CYCLES) / `CLK_PERIOD_NS)
`define CONV_SYS_CYCLES (`CONV_CYCLES * `TICK_SYS)
`endif

// ### logic/data_converter_control_pkg.sv
// Types shared by the data converter control logic
package data_converter_control_pkg;
   typedef enum logic {ST_IDLE, ST_RUN} conv_state_type;
   typedef struct packed {
      logic connect;
      logic temp_sel;
      logic [1:0] trig;
      logic diff;
      logic [2:0] chan;
   } mux_cfg_type;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } reg_req_type;
endpackage

// ### logic/dual_mode_data_converter_ctrl.sv
// Register file, mode control and result formatting of the data converter
`include "data_converter_control_cfg.svh"
module dual_mode_data_converter_ctrl (
   input wire logic core_clk, // 10 MHz system clock
   input wire logic sys_rst, // Synchronous reset, active high
   input wire data_converter_control_pkg::reg_req_type bus_req, // Strobes, address, write data
   output logic [7:0] rd_data, // Read data, cycle after read strobe
   input wire logic [2:0] timer_ovf, // Timer 0..2 overflow pulses
   input wire logic cmp_pin, // Comparator: input at or above trial
   output data_converter_control_pkg::mux_cfg_type mux_cfg, // Multiplexer setting
   output logic [1:0] internal_src, // 01 supply, 10 temperature
   output logic ref_internal, // 1: internal 1.0V, 0: half supply
   output logic analog_enable, // Analog power on
   output logic dac_active, // Second port pins driven by DAC
   output logic sample_track, // Sample-and-hold tracking
   output logic [9:0] sar_trial, // Trial code to the comparator
   output logic [9:0] dac_level, // Offset-binary output level
   output logic conv_irq // Conversion complete request
);
   import data_converter_control_pkg::*;

   function automatic logic [15:0] align_word(input logic [9:0] code, input logic left);
      return left ? {code, 6'h00} : {{6{code[9]}}, code};
   endfunction

   function automatic logic [9:0] unalign_word(input logic [15:0] word, input logic left);
      return left ? word[15:6] : word[9:0];
   endfunction

   logic en;
   logic left_align_select;
   logic dac_sel;
   logic refi;
   logic done_flag;
   logic refused_flag;
   logic overrun_flag;
   logic [15:0] data_word;
   logic cmp_meta;
   logic cmp_sync;
   logic eng_busy;
   logic eng_done;
   logic [9:0] eng_result;

   logic wr_ctl;
   logic wr_sel;
   logic wr_lo;
   logic wr_hi;
   logic rd_lo;
   logic rd_hi;
   logic en_now;
   logic sw_start;
   logic trig_hit;
   logic start_req;
   logic sel_locked;
   logic sel_changes_route;
   logic sel_refuse;
   logic [9:0] adc_code;
   logic [15:0] adc_word;
   logic [9:0] dac_code;
   logic [7:0] ctl_view;
   logic [7:0] next_rd;
   mux_cfg_type next_sel;
   mux_cfg_type wsel;
   logic int_chan;
   logic [1:0] next_src;

   // Address decode
   assign wr_ctl = bus_req.wr && (bus_req.addr == `CTL_ADDR);
   assign wr_sel = bus_req.wr && (bus_req.addr == `SEL_ADDR);
   assign wr_lo = bus_req.wr && (bus_req.addr == `RLO_ADDR) && dac_sel;
   assign wr_hi = bus_req.wr && (bus_req.addr == `RHI_ADDR) && dac_sel;
   assign rd_lo = bus_req.rd && (bus_req.addr == `RLO_ADDR) && !dac_sel;
   assign rd_hi = bus_req.rd && (bus_req.addr == `RHI_ADDR) && !dac_sel;

   // Starting a conversion
   assign en_now = wr_ctl ? bus_req.wdata[`CTL_EN] : en;
   assign sw_start = wr_ctl && bus_req.wdata[`CTL_GO];
   assign trig_hit = (mux_cfg.trig != 2'h0) && timer_ovf[2'(mux_cfg.trig - 2'h1)];
   assign start_req = en_now && !eng_busy && (sw_start || trig_hit);

   // Routing changes only while disconnected and idle
   assign wsel = mux_cfg_type'(bus_req.wdata);
   assign sel_locked = eng_busy || mux_cfg.connect;
   assign sel_changes_route = (wsel.chan != mux_cfg.chan) || (wsel.diff != mux_cfg.diff) ||
                              (wsel.temp_sel != mux_cfg.temp_sel);
   assign sel_refuse = wr_sel && sel_locked && sel_changes_route;
   assign next_sel = sel_refuse ?
                     mux_cfg_type'({!eng_busy ? wsel.connect : mux_cfg.connect,
                                    mux_cfg.temp_sel, wsel.trig, mux_cfg.diff, mux_cfg.chan}) :
                     wsel;

   // Internal channels sit on differential position three
   assign int_chan = next_sel.connect && next_sel.diff && (next_sel.chan == `INT_CHAN);
   assign next_src = int_chan ? (next_sel.temp_sel ? 2'h2 : 2'h1) : 2'h0;

   // Result formatting
   assign adc_code = {~eng_result[9], eng_result[8:0]};
   assign adc_word = align_word(adc_code, left_align_select);
   assign dac_code = unalign_word(data_word, left_align_select) ^ `CODE_MID;

   // Read path
   assign ctl_view = {en, eng_busy, left_align_select, done_flag, dac_sel, refi, refused_flag, overrun_flag};
   assign next_rd = !bus_req.rd ? 8'h00 :
                    (bus_req.addr == `CTL_ADDR) ? ctl_view :
                    (bus_req.addr == `SEL_ADDR) ? 8'(mux_cfg) :
                    rd_lo ? adc_word[7:0] :
                    rd_hi ? adc_word[15:8] :
                    8'h00;

   // Comparator synchroniser
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cmp_meta <= 1'b0;
         cmp_sync <= 1'b0;
      end else begin
         cmp_meta <= cmp_pin;
         cmp_sync <= cmp_meta;
      end
   end

   // Control register
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         en <= 1'b0;
         left_align_select <= 1'b0;
         dac_sel <= 1'b0;
         refi <= 1'b0;
      end else if (wr_ctl) begin
         en <= bus_req.wdata[`CTL_EN];
         left_align_select <= bus_req.wdata[`CTL_LEFT_ALIGN_SELECT];
         dac_sel <= bus_req.wdata[`CTL_DAC];
         refi <= bus_req.wdata[`CTL_REFI];
      end
   end

   // Sticky flags, hardware set wins over software clear
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         done_flag <= 1'b0;
         refused_flag <= 1'b0;
         overrun_flag <= 1'b0;
      end else begin
         if (eng_done) done_flag <= 1'b1;
         else if (wr_ctl && !bus_req.wdata[`CTL_DONE]) done_flag <= 1'b0;
         if (sel_refuse) refused_flag <= 1'b1;
         else if (wr_ctl && !bus_req.wdata[`CTL_REFUSED]) refused_flag <= 1'b0;
         if (trig_hit && eng_busy) overrun_flag <= 1'b1;
         else if (wr_ctl && !bus_req.wdata[`CTL_OVERRUN]) overrun_flag <= 1'b0;
      end
   end

   // Input selection register
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         mux_cfg <= mux_cfg_type'(`SEL_RST);
         internal_src <= 2'h0;
      end else if (wr_sel) begin
         mux_cfg <= next_sel;
         internal_src <= next_src;
      end
   end

   // Output value for DAC mode
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         data_word <= `WORD_RST;
      end else begin
         if (wr_lo) data_word[7:0] <= bus_req.wdata;
         if (wr_hi) data_word[15:8] <= bus_req.wdata;
      end
   end

   // Registered pin-side outputs
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rd_data <= 8'h00;
         ref_internal <= 1'b0;
         analog_enable <= 1'b0;
         dac_active <= 1'b0;
         conv_irq <= 1'b0;
      end else begin
         rd_data <= next_rd;
         ref_internal <= refi || (internal_src != 2'h0);
         analog_enable <= en;
         dac_active <= en && dac_sel && mux_cfg.connect;
         conv_irq <= done_flag;
      end
   end

   sar_engine engine (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .start(start_req),
      .abort(!en_now),
      .dac_mode(dac_sel),
      .cmp_high(cmp_sync),
      .dac_value(dac_code),
      .busy(eng_busy),
      .done(eng_done),
      .sample_track(sample_track),
      .trial(sar_trial),
      .result(eng_result),
      .dac_level(dac_level)
   );

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   busy_clear_a: assert property (
      eng_done |-> !eng_busy ##1 done_flag) else $error("busy or done flag wrong at end");
   start_enabled_a: assert property (
      $rose(eng_busy) |-> en) else $error("conversion started while disabled");
   right_fill_a: assert property (
      rd_hi && !left_align_select |=> rd_data[7:2] == {6{rd_data[1]}}) else $error("sign not extended");
   left_zero_a: assert property (
      rd_lo && left_align_select |=> rd_data[5:0] == 6'h00) else $error("low bits not zero");
   dac_read_zero_a: assert property (
      bus_req.rd && dac_sel && (bus_req.addr == `RLO_ADDR || bus_req.addr == `RHI_ADDR)
      |=> rd_data == 8'h00) else $error("data readable in dac mode");
   adc_write_keep_a: assert property (
      bus_req.wr && !dac_sel && bus_req.addr == `RHI_ADDR |=> $stable(data_word))
      else $error("data written in adc mode");
   result_sign_a: assert property (
      rd_hi && left_align_select |=> rd_data[7] == ~$past(eng_result[9])) else $error("result not two's complement");
   irq_follow_a: assert property (
      eng_done |-> ##2 conv_irq) else $error("no interrupt after conversion");
   flag_set_wins_a: assert property (
      eng_done && wr_ctl && !bus_req.wdata[`CTL_DONE] |=> done_flag) else $error("done flag lost");
   read_once_a: assert property (
      !bus_req.rd |=> rd_data == 8'h00) else $error("read data held too long");

   en_follow_a: assert property (
      en |=> analog_enable)
      else $error("enable not passed to analog side");
   en_off_a: assert property (
      !en |=> !analog_enable)
      else $error("analog side powered while disabled");
   off_idle_a: assert property (
      !en |-> !eng_busy)
      else $error("engine busy while disabled");
   start_busy_a: assert property (
      start_req |=> eng_busy)
      else $error("accepted start did not set busy");
   no_start_off_a: assert property (
      sw_start && !en_now |=> !eng_busy)
      else $error("start accepted while disabled");
   dac_drive_a: assert property (
      en && dac_sel && mux_cfg.connect |=> dac_active)
      else $error("dac pins not driven");
   adc_no_drive_a: assert property (
      !dac_sel |=> !dac_active)
      else $error("dac pins driven in adc mode");
   irq_low_a: assert property (
      !done_flag |=> !conv_irq)
      else $error("request without done flag");
   ref_select_a: assert property (
      refi |=> ref_internal)
      else $error("internal reference not selected");
   ref_half_a: assert property (
      !refi && internal_src == 2'h0 |=> !ref_internal)
      else $error("half supply reference not selected");
   int_ref_a: assert property (
      internal_src != 2'h0 |=> ref_internal)
      else $error("internal channel without internal reference");
   int_route_a: assert property (
      internal_src != 2'h0 |-> mux_cfg.connect && mux_cfg.diff && mux_cfg.chan == `INT_CHAN)
      else $error("internal channel on wrong position");
   ctl_read_a: assert property (
      bus_req.rd && bus_req.addr == `CTL_ADDR |=> rd_data == $past(ctl_view))
      else $error("control read wrong");
   low_read_a: assert property (
      rd_lo |=> rd_data == $past(adc_word[7:0]))
      else $error("low result byte wrong");
   high_read_a: assert property (
      rd_hi |=> rd_data == $past(adc_word[15:8]))
      else $error("high result byte wrong");
   left_high_a: assert property (
      rd_hi && left_align_select |=> rd_data == $past(adc_code[9:2]))
      else $error("left aligned high byte wrong");
   adc_low_keep_a: assert property (
      bus_req.wr && !dac_sel && bus_req.addr == `RLO_ADDR |=> $stable(data_word))
      else $error("low byte written in adc mode");
   dac_write_a: assert property (
      wr_hi |=> data_word[15:8] == $past(bus_req.wdata))
      else $error("high byte not written in dac mode");
   done_clear_a: assert property (
      wr_ctl && !bus_req.wdata[`CTL_DONE] && !eng_done |=> !done_flag)
      else $error("done flag not cleared");
   done_keep_a: assert property (
      done_flag && !wr_ctl |=> done_flag)
      else $error("done flag dropped by itself");
   sel_refuse_a: assert property (
      sel_refuse |=> $stable(mux_cfg.chan))
      else $error("refused channel change applied");
   busy_route_a: assert property (
      eng_busy |=> $stable(mux_cfg.chan) && $stable(mux_cfg.diff))
      else $error("route changed during conversion");
   trig_busy_a: assert property (
      trig_hit && eng_busy |=> overrun_flag)
      else $error("trigger overrun not flagged");
   conv_sample_a: assert property (
      sample_track |-> eng_busy)
      else $error("sampling outside a conversion");
endmodule

// ### logic/sar_engine.sv
// Successive approximation sequencer for conversions in both directions
`include "data_converter_control_cfg.svh"
module sar_engine (
   input wire logic core_clk, // System clock
   input wire logic sys_rst, // Synchronous reset
   input wire logic start, // Begin a conversion
   input wire logic abort, // Converter disabled
   input wire logic dac_mode, // Reverse direction
   input wire logic cmp_high, // Input at or above trial level
   input wire logic [9:0] dac_value, // Offset-binary output value
   output logic busy, // Conversion running
   output logic done, // End of conversion pulse
   output logic sample_track, // High while input is sampled
   output logic [9:0] trial, // Trial code to the comparator
   output logic [9:0] result, // Offset-binary conversion result
   output logic [9:0] dac_level // Offset-binary output level
);
   import data_converter_control_pkg::*;
   conv_state_type state;
   logic [2:0] pre;
   logic [3:0] cyc;
   logic [9:0] buffer;
   logic run_dac;
   logic [6:0] run_cnt;
   logic tick;
   logic last;
   logic [3:0] bit_pos;
   logic [9:0] bit_mask;
   logic [9:0] kept;
   logic step;

   assign tick = (state == ST_RUN) && (pre == 3'(`TICK_SYS - 1));
   assign last = tick && (cyc == 4'(`CONV_CYCLES));
   assign bit_pos = 4'(`CONV_CYCLES) - cyc;
   assign bit_mask = 10'h001 << bit_pos;
   assign kept = cmp_high ? trial : (trial & ~bit_mask);
   assign step = tick && !run_dac && (cyc > `SAMPLE_CYC);

   always_ff @(posedge core_clk) begin
      if (sys_rst || abort) begin
         state <= ST_IDLE;
         pre <= 3'h0;
         cyc <= 4'h0;
         busy <= 1'b0;
         done <= 1'b0;
         sample_track <= 1'b0;
         trial <= 10'h000;
      end else begin
         done <= 1'b0;
         unique case (state)
            ST_IDLE: if (start) begin
               state <= ST_RUN;
               busy <= 1'b1;
               pre <= 3'h0;
               cyc <= 4'h1;
            end
            ST_RUN: begin
               pre <= tick ? 3'h0 : pre + 3'h1;
               if (tick) begin
                  cyc <= cyc + 4'h1;
                  sample_track <= !run_dac && (cyc == `SAMPLE_CYC - 4'h1);
               end
               if (tick && run_dac && cyc == 4'h1) begin
                  trial <= buffer;
               end else if (tick && !run_dac && cyc == `SAMPLE_CYC) begin
                  trial <= `CODE_MID;
               end else if (step) begin
                  trial <= kept | (bit_mask >> 1);
               end
               if (last) begin
                  state <= ST_IDLE;
                  busy <= 1'b0;
                  done <= 1'b1;
                  cyc <= 4'h0;
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         buffer <= 10'h000;
         run_dac <= 1'b0;
         result <= `CODE_MID;
         dac_level <= 10'h000;
      end else if (state == ST_IDLE && start && !abort) begin
         buffer <= dac_value;
         run_dac <= dac_mode;
      end else if (tick && !abort) begin
         if (!run_dac && cyc == 4'(`CONV_CYCLES)) result <= kept;
         if (run_dac && cyc == 4'(`CONV_CYCLES - 1)) dac_level <= buffer;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) run_cnt <= 7'h00;
      else if (state == ST_IDLE && start) run_cnt <= 7'h00;
      else if (state == ST_RUN) run_cnt <= run_cnt + 7'h01;
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   conv_length_a: assert property (
      done |-> run_cnt == 7'(`CONV_SYS_CYCLES)) else $error("conversion length wrong");
   sample_third_a: assert property (
      sample_track |-> cyc == `SAMPLE_CYC && !run_dac) else $error("sample outside third cycle");
   hold_after_a: assert property (
      busy && cyc > `SAMPLE_CYC |-> !sample_track) else $error("input tracked after sampling");
   dac_update_a: assert property (
      !$stable(dac_level) |-> run_dac && cyc == 4'(`CONV_CYCLES)) else $error("dac level moved early");
endmodule

// ### testbench/analog_front_model.sv
// Comparator and sample-and-hold front end facing the converter
module analog_front_model (
   input wire logic core_clk, // System clock
   input wire logic powered, // Analog power on
   input wire logic sample_track, // Track while high
   input wire logic [9:0] trial, // Trial code, offset binary
   input wire logic [9:0] level, // Input level, offset binary
   input wire logic slow, // Answer one cycle later
   output logic cmp_pin // Held level at or above trial
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [9:0] held = 10'h000;
   logic late = 1'b0;
   logic junk = 1'b0;
   always @(posedge core_clk) begin
      if (sample_track) begin
         held <= level;
      end
      late <= held >= trial;
      junk <= ~junk;
   end
   // Unpowered comparator wanders
   assign cmp_pin = !powered ? junk : slow ? late : (held >= trial);
endmodule

// ### testbench/dual_mode_data_converter_ctrl_tb_top.sv
// Self-checking bench of the data converter control block
module dual_mode_data_converter_ctrl_tb_top
   import data_converter_control_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   reg_req_type bus_req = '0;
   logic [2:0] timer_ovf = 3'h0;
   logic [9:0] level = 10'h000;
   logic slow = 1'b0;
   logic cmp_pin;
   logic [7:0] rd_data;
   mux_cfg_type mux_cfg;
   logic [1:0] internal_src;
   logic ref_internal, analog_enable, dac_active, sample_track, conv_irq;
   logic [9:0] sar_trial, dac_level;
   logic rd_seen = 1'b0;
   logic [7:0] exp_q[$];
   logic [9:0] codes [5] = '{10'h000, 10'h100, 10'h1ff, 10'h300, 10'h201};
   int fail_count = 0;
   int n_tests = 0;

   dual_mode_data_converter_ctrl dut (.core_clk(core_clk), .sys_rst(sys_rst), .bus_req(bus_req),
      .rd_data(rd_data), .timer_ovf(timer_ovf), .cmp_pin(cmp_pin), .mux_cfg(mux_cfg),
      .internal_src(internal_src), .ref_internal(ref_internal), .analog_enable(analog_enable),
      .dac_active(dac_active), .sample_track(sample_track), .sar_trial(sar_trial),
      .dac_level(dac_level), .conv_irq(conv_irq));
   analog_front_model front (.core_clk(core_clk), .powered(analog_enable), .sample_track(sample_track),
      .trial(sar_trial), .level(level), .slow(slow), .cmp_pin(cmp_pin));

   initial begin
      forever #50 core_clk = ~core_clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // One bus cycle; a read notes its expected byte
   task automatic bus(input logic wr, input logic [3:0] addr, input logic [7:0] d);
      @(posedge core_clk);
      bus_req <= {wr, ~wr, addr, wr ? d : 8'h00};
      if (!wr) exp_q.push_back(d);
      @(posedge core_clk);
      bus_req <= '0;
   endtask

   task automatic pulse(input logic [2:0] m);
      @(posedge core_clk);
      timer_ovf <= m;
      @(posedge core_clk);
      timer_ovf <= 3'h0;
   endtask

   always @(posedge core_clk) rd_seen <= bus_req.rd;
   always @(negedge core_clk) begin
      if (rd_seen) check({8'h00, rd_data}, {8'h00, exp_q.pop_front()});
   end

   // Count cycles to the request; input moves after the hold point
   task automatic wait_irq(input int start, output int n, input logic [9:0] swap);
      n = start;
      while (conv_irq !== 1'b1) begin
         @(posedge core_clk);
         #1;
         n++;
         if (n == 30) level = swap;
         if (n > 200) begin
            check(16'(conv_irq), 16'h0001);
            final_report();
         end
      end
   endtask

   task automatic settle;
      repeat (2) @(posedge core_clk);
      #1;
   endtask

   task automatic set_sel(input logic [7:0] s, input logic [1:0] src);
      bus(1, 4'h1, 8'h00);
      bus(1, 4'h1, s & 8'h7f);
      bus(1, 4'h1, s);
      settle();
      check({14'h0, internal_src}, {14'h0, src});
      check(16'(ref_internal), 16'(src != 2'b00));
   endtask

   task automatic run_adc(input logic [9:0] lvl, input logic left, input logic [1:0] trig);
      logic [2:0] ch;
      logic [9:0] code;
      logic [15:0] word;
      int n;
      ch = 3'($urandom % 7);
      code = lvl ^ 10'h200;
      word = left ? {code, 6'h00} : {{6{code[9]}}, code};
      level <= lvl;
      slow <= 1'($urandom);
      bus(1, 4'h1, 8'h00);
      bus(1, 4'h1, {2'b00, trig, 1'b0, ch});
      bus(1, 4'h1, {2'b10, trig, 1'b0, ch});
      if (trig == 2'h0) begin
         bus(1, 4'h0, {2'b11, left, 5'h00});
      end else begin
         bus(1, 4'h0, {2'b10, left, 5'h00});
         pulse(~(3'h1 << (trig - 1)));
         bus(0, 4'h0, {2'b10, left, 5'h00});
         pulse(3'h1 << (trig - 1));
      end
      bus(0, 4'h0, {2'b11, left, 5'h00});
      wait_irq(2, n, ~lvl);
      if (trig == 2'h0) check(16'(n), 16'd67);
      bus(0, 4'h2, word[7:0]);
      bus(0, 4'h3, word[15:8]);
      bus(0, 4'h0, {2'b10, left, 5'h10});
      bus(1, 4'h2, ~word[7:0]);
      bus(1, 4'h3, ~word[15:8]);
      bus(0, 4'h2, word[7:0]);
      check({6'h00, mux_cfg, dac_active, ref_internal}, {6'h00, 2'b10, trig, 1'b0, ch, 2'b00});
      bus(1, 4'h0, {2'b10, left, 5'h00});
      settle();
      check(16'(conv_irq), 16'h0000);
   endtask

   task automatic run_dac(input logic [9:0] v, input logic left);
      logic [15:0] word;
      int n;
      word = left ? {v, 6'h00} : {{6{v[9]}}, v};
      bus(1, 4'h0, {2'b10, left, 5'h08});
      bus(1, 4'h1, 8'h00);
      bus(1, 4'h1, 8'h80);
      bus(1, 4'h2, word[7:0]);
      bus(1, 4'h3, word[15:8]);
      bus(0, 4'h3, 8'h00);
      bus(1, 4'h0, {2'b11, left, 5'h08});
      wait_irq(0, n, level);
      check({5'h00, dac_active, dac_level}, {6'h01, v ^ 10'h200});
      bus(1, 4'h0, {2'b10, left, 5'h08});
      settle();
   endtask

   initial begin
      void'($urandom(92491));
      repeat (12) @(posedge core_clk);
      sys_rst <= 1'b0;
      bus(0, 4'h0, 8'h00);
      bus(0, 4'h1, 8'h00);
      bus(0, 4'h2, 8'h00);
      bus(0, 4'h3, 8'h00);
      bus(1, 4'h9, 8'hff);
      bus(0, 4'h9, 8'h00);
      bus(1, 4'h0, 8'h40);
      bus(0, 4'h0, 8'h00);
      check(16'(analog_enable), 16'h0000);
      set_sel(8'h8b, 2'b01);
      set_sel(8'hcb, 2'b10);
      set_sel(8'h80, 2'b00);
      bus(1, 4'h0, 8'h84);
      settle();
      check({14'h0, analog_enable, ref_internal}, 16'h0003);
      foreach (codes[i]) for (int l = 0; l < 2; l++) run_adc(codes[i] ^ 10'h200, l[0], 2'h0);
      for (int t = 1; t < 4; t++) run_adc(10'($urandom), 1'($urandom), t[1:0]);
      for (int l = 0; l < 2; l++) run_dac(10'($urandom), l[0]);
      final_report();
   end
endmodule
